// ==== verilog/latch_loader.sv ====
// Three-wire serial latch loader with AXI4-Lite register access
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`include "latch_loader_params.svh"

module latch_loader (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Serial programming pins
  input  wire logic        serial_clk,
  input  wire logic        serial_data,
  input  wire logic        load_strobe,
  input  wire logic        chip_enable,
  // Internal signals for the monitor and charge pump outputs
  input  wire logic        reference_clock_in,
  input  wire logic        rf_scaled_in,
  input  wire logic        lock_detect_in,
  input  wire logic        pump_drive_in,
  // Device pins
  output logic             mux_monitor_out,
  output logic             charge_pump_out,
  output logic             charge_pump_oe,
  output logic             powered_up,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Interrupt
  output logic             irq
);

  // ==========================================================================
  // Helper functions

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address is one of the mapped words
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `OFF_STATE);
  endfunction

  // ==========================================================================
  // Pin synchronisers

  logic [6:0] pins_lvl;    // Filtered pin levels
  logic       sclk_s;      // Serial clock level
  logic       sdata_s;     // Serial data level
  logic       strobe_s;    // Load strobe level
  logic       ce_s;        // Chip enable level
  logic       ref_s;       // Reference level
  logic       rf_s;        // Scaled RF level
  logic       lock_s;      // Lock detect level

  pin_sync #(
    .WIDTH (7)
  ) u_pins (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    ({lock_detect_in, rf_scaled_in, reference_clock_in, chip_enable,
                 load_strobe, serial_data, serial_clk}),
    .level_out (pins_lvl)
  );

  assign {lock_s, rf_s, ref_s, ce_s, strobe_s, sdata_s, sclk_s} = pins_lvl;

  // ==========================================================================
  // Edge detection

  logic sclk_d_r;      // Serial clock, one cycle late
  logic strobe_d_r;    // Load strobe, one cycle late
  logic sclk_rise;     // Serial clock rising
  logic strobe_rise;   // Load strobe rising

  assign sclk_rise   = sclk_s & ~sclk_d_r;
  assign strobe_rise = strobe_s & ~strobe_d_r;

  // Previous levels for edge finding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_d_r   <= 1'b0;
      strobe_d_r <= 1'b0;
    end else begin
      sclk_d_r   <= sclk_s;
      strobe_d_r <= strobe_s;
    end
  end

  // ==========================================================================
  // Shift register and latches

  latch_loader_pkg::word_t      shift_r;      // Input shift register
  latch_loader_pkg::word_t      ctrl_latch_r; // Control latch
  latch_loader_pkg::word_t      r_latch_r;    // R counter latch
  latch_loader_pkg::word_t      n_latch_r;    // N counter latch
  latch_loader_pkg::word_t      test_latch_r; // Test modes latch
  latch_loader_pkg::latch_sel_t sel;          // Destination of next load

  assign sel = latch_loader_pkg::latch_sel_t'(shift_r[`SEL_LSB +: 2]); // R02

  // Shift on serial clock rise, oldest bit falls off the top
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_r <= `LATCH_RESET;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[`WORD_BITS-2:0], sdata_s}; // R01 R02 R10
    end
  end

  // Copy into the selected latch only on strobe rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_latch_r <= `LATCH_RESET;
      r_latch_r    <= `LATCH_RESET;
      n_latch_r    <= `LATCH_RESET;
      test_latch_r <= `LATCH_RESET;
    end else if (strobe_rise) begin // R03 R10
      unique case (sel) // R07
        latch_loader_pkg::SEL_CONTROL: ctrl_latch_r <= shift_r;
        latch_loader_pkg::SEL_R_COUNT: r_latch_r    <= shift_r;
        latch_loader_pkg::SEL_N_COUNT: n_latch_r    <= shift_r;
        latch_loader_pkg::SEL_TEST:    test_latch_r <= shift_r; // R08
      endcase
    end
  end

  // ==========================================================================
  // Power and charge pump

  logic soft_pd;      // Programmed power-down request
  logic pump_off;     // Programmed pump three-state
  logic powered_nxt;  // Device running

  assign soft_pd     = ctrl_latch_r[`PD_A_BIT];
  assign pump_off    = ctrl_latch_r[`PUMP_OFF_BIT];
  assign powered_nxt = ce_s & ~soft_pd; // R04 R05

  // Power state and pump drive, all from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powered_up      <= 1'b0;
      charge_pump_oe  <= 1'b0;
      charge_pump_out <= 1'b0;
    end else begin
      powered_up      <= powered_nxt;                // R05
      charge_pump_oe  <= powered_nxt & ~pump_off;    // R04
      charge_pump_out <= powered_nxt & pump_drive_in;
    end
  end

  // ==========================================================================
  // Monitor output multiplexer

  latch_loader_pkg::mon_src_t mon_src; // Programmed source
  logic                       mon_nxt; // Selected level

  assign mon_src = latch_loader_pkg::mon_src_t'(ctrl_latch_r[`MUX_LSB +: 3]);
  assign mon_nxt = (mon_src == latch_loader_pkg::MON_LOCK)      ? lock_s :
                   (mon_src == latch_loader_pkg::MON_RF_SCALE)  ? rf_s   :
                   (mon_src == latch_loader_pkg::MON_REF_SCALE) ? ref_s  :
                   (mon_src == latch_loader_pkg::MON_HIGH);     // R06

  // Registered monitor pin, held low while powered down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mux_monitor_out <= 1'b0;
    end else begin
      mux_monitor_out <= powered_nxt & mon_nxt; // R06
    end
  end

  // ==========================================================================
  // Event status and interrupt

  logic [`EVENT_BITS-1:0] status_r;   // Sticky events
  logic [`EVENT_BITS-1:0] mask_r;     // Interrupt enables
  logic [`EVENT_BITS-1:0] ev_set;     // Events this cycle
  logic [`EVENT_BITS-1:0] ev_clr;     // Write-one clears this cycle
  logic                   ce_d_r;     // Chip enable, one cycle late
  logic                   do_write;   // Register write fires
  logic [7:0]             wr_addr_r;  // Held write address
  logic [31:0]            wr_data_r;  // Held write data
  logic [3:0]             wr_strb_r;  // Held write strobes

  // Bits 0..3 latch loads, bit 4 chip enable change
  assign ev_set = {ce_s ^ ce_d_r,
                   strobe_rise && sel == latch_loader_pkg::SEL_TEST,
                   strobe_rise && sel == latch_loader_pkg::SEL_N_COUNT,
                   strobe_rise && sel == latch_loader_pkg::SEL_R_COUNT,
                   strobe_rise && sel == latch_loader_pkg::SEL_CONTROL};
  assign ev_clr = (do_write && wr_addr_r == `OFF_STATUS && wr_strb_r[0])
                  ? wr_data_r[`EVENT_BITS-1:0] : '0;

  // Set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
      ce_d_r   <= 1'b0;
      irq      <= 1'b0;
    end else begin
      status_r <= (status_r & ~ev_clr) | ev_set;
      ce_d_r   <= ce_s;
      irq      <= |(status_r & mask_r);
    end
  end

  // ==========================================================================
  // AXI4-Lite write side

  logic aw_held_r;  // Address captured
  logic w_held_r;   // Data captured

  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
  assign do_write      = aw_held_r & w_held_r & ~s_axi_bvalid;

  // Capture address and data in either order, answer once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      wr_addr_r    <= 8'h00;
      wr_data_r    <= 32'h0000_0000;
      wr_strb_r    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        wr_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r  <= 1'b1;
        wr_data_r <= s_axi_wdata;
        wr_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_mapped(wr_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic [31:0] mask_merged;  // Mask word after lane merge

  assign mask_merged = lane_merge({27'h0, mask_r}, wr_data_r, wr_strb_r);

  // Mask register, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= '0;
    end else if (do_write && wr_addr_r == `OFF_MASK) begin
      mask_r <= mask_merged[`EVENT_BITS-1:0];
    end
  end

  // ==========================================================================
  // AXI4-Lite read side

  logic [31:0] rd_word;  // Decoded read value

  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_word =
    (s_axi_araddr == `OFF_STATUS)     ? {27'h0, status_r}     :
    (s_axi_araddr == `OFF_MASK)       ? {27'h0, mask_r}       :
    (s_axi_araddr == `OFF_CTRL_LATCH) ? {8'h00, ctrl_latch_r} :
    (s_axi_araddr == `OFF_R_LATCH)    ? {8'h00, r_latch_r}    :
    (s_axi_araddr == `OFF_N_LATCH)    ? {8'h00, n_latch_r}    :
    (s_axi_araddr == `OFF_TEST_LATCH) ? {8'h00, test_latch_r} :
    (s_axi_araddr == `OFF_SHIFT)      ? {8'h00, shift_r}      :
    (s_axi_araddr == `OFF_STATE)      ? {29'h0, charge_pump_oe, ce_s, powered_up} :
                                        32'h0000_0000;

  // One read at a time, data registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== verilog/latch_loader_params.svh ====
// Offsets, field positions, reset values and timing counts of the serial latch loader
// ==========================================================================
// Behaviour
// R01 - Shift serial data on serial clock rise
// R02 - MSB first; last two bits select latch
// R03 - Load strobe rise copies word to latch
// R04 - Chip enable low: power down, pump three-stated
// R05 - Chip enable high: obey programmed power-down bits (code obeys only PD_A_BIT, bit 20; PD_B_BIT is unused)
// R06 - Monitor output drives selected internal signal
// R07 - 00 control, 01 R, 10 N, 11 test
// R08 - Host never writes the test latch
// R09 - Host writes R, control, then N
// R10 - Keep last 24 bits; latches change on strobe
`ifndef LATCH_LOADER_PARAMS_SVH
`define LATCH_LOADER_PARAMS_SVH

// ==========================================================================
// Serial word layout
`define WORD_BITS        24
`define SEL_LSB          0
`define MUX_LSB          5
`define PUMP_OFF_BIT     9
`define PD_A_BIT         20
`define PD_B_BIT         21

// ==========================================================================
// Register byte offsets
`define OFF_STATUS       8'h00
`define OFF_MASK         8'h04
`define OFF_CTRL_LATCH   8'h08
`define OFF_R_LATCH      8'h0C
`define OFF_N_LATCH      8'h10
`define OFF_TEST_LATCH   8'h14
`define OFF_SHIFT        8'h18
`define OFF_STATE        8'h1C

// ==========================================================================
// Reset values and bus answers
`define LATCH_RESET      24'h00_0000
`define EVENT_BITS       5
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// ==========================================================================
// Pin synchroniser depth
`define SYNC_STAGES      3

`endif

// ==== verilog/latch_loader_pkg.sv ====
// Types shared by the serial latch loader
package latch_loader_pkg;

  // Destination latch picked by the two low word bits
  typedef enum logic [1:0] {
    SEL_CONTROL = 2'b00,
    SEL_R_COUNT = 2'b01,
    SEL_N_COUNT = 2'b10,
    SEL_TEST    = 2'b11
  } latch_sel_t;

  // Monitor output source
  typedef enum logic [2:0] {
    MON_LOW      = 3'b000,
    MON_LOCK     = 3'b001,
    MON_RF_SCALE = 3'b010,
    MON_REF_SCALE= 3'b011,
    MON_HIGH     = 3'b111
  } mon_src_t;

  // One serial word
  typedef logic [23:0] word_t;

endpackage

// ==== verilog/pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Raw pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] st1_r;   // First stage, read only by second
  logic [WIDTH-1:0] st2_r;   // Second stage
  logic [WIDTH-1:0] st3_r;   // Third stage
  logic [WIDTH-1:0] agree;   // Stages two and three match

  assign agree = ~(st2_r ^ st3_r);

  // Chain and filtered level update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st1_r     <= '0;
      st2_r     <= '0;
      st3_r     <= '0;
      level_out <= '0;
    end else begin
      st1_r     <= pin_in;
      st2_r     <= st1_r;
      st3_r     <= st2_r;
      // Take a change only once two stages agree
      level_out <= (agree & st3_r) | (~agree & level_out);
    end
  end

endmodule

// ==== verif/latch_loader_assertions.sv ====
// Port-level checker for the serial latch loader
`include "latch_loader_params.svh"

module latch_loader_assertions (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Pins
  input wire logic        chip_enable,
  input wire logic        powered_up,
  input wire logic        charge_pump_oe,
  input wire logic        mux_monitor_out,
  input wire logic        irq,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  // ==================================================
  // Shared clock and reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==================================================
  // Pins
  // Chip enable held low forces power down and pump off
  property p_ce_down;
    !chip_enable [*7] |-> !powered_up && !charge_pump_oe;
  endproperty
  a_ce_down: assert property (p_ce_down)
    else $error("device up while chip enable low");
  // Pump driven only from a powered device
  property p_oe_power;
    charge_pump_oe |-> powered_up || $past(powered_up);
  endproperty
  a_oe_power: assert property (p_oe_power)
    else $error("pump driven while powered down");
  // Power up only after chip enable has been high a while
  property p_rise_ce;
    $rose(powered_up) |-> $past(chip_enable, 3);
  endproperty
  a_rise_ce: assert property (p_rise_ce)
    else $error("power up without chip enable");
  // Monitor quiet while powered down
  property p_mon_quiet;
    !powered_up [*2] |-> !mux_monitor_out;
  endproperty
  a_mon_quiet: assert property (p_mon_quiet)
    else $error("monitor active while powered down");

  // ==================================================
  // Register bus
  // Write answer follows both halves
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer)
    else $error("write response missing");
  // Read answer one edge after address
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read response missing");
  // Write response stands until taken
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stands: assert property (p_b_stands)
    else $error("write response dropped");
  // Read data stands until taken
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp);
  endproperty
  a_r_stands: assert property (p_r_stands)
    else $error("read data dropped");
  // No new requests while an answer is pending
  property p_busy_refuse;
    (s_axi_rvalid |-> !s_axi_arready) and (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("request taken while answer pending");

  // ==================================================
  // Main scenarios
  c_irq: cover property ($rose(irq));
  c_power: cover property ($rose(powered_up));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
  c_mon: cover property ($rose(mux_monitor_out));
endmodule

bind latch_loader latch_loader_assertions u_chk (
  .aclk, .aresetn, .chip_enable, .powered_up, .charge_pump_oe, .mux_monitor_out, .irq,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp
);

// ==== verif/serial_host.sv ====
// Host model driving the three-wire programming pins
module serial_host (
  // Clock
  input wire logic aclk,
  // Serial pins
  output logic     serial_clk,
  output logic     serial_data,
  output logic     load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle pins at time zero
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  // Wait whole clock cycles
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // One bit: data set with clock low, 200 ns clock period
  task automatic put_bit(input logic b);
    serial_clk <= 1'b0;
    serial_data <= b;
    wt(4);
    serial_clk <= 1'b1;
    wt(4);
  endtask

  // Clock low, data no longer held
  task automatic idle_line();
    serial_clk <= 1'b0;
    serial_data <= ~serial_data;
    wt(4);
  endtask

  // Eight extra bits, never loaded
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    idle_line();
  endtask

  // Whole word, strobe only after the last bit
  task automatic send_word(input latch_loader_pkg::word_t w, input logic load);
    for (int i = 23; i >= 0; i--) begin
      put_bit(w[i]);
    end
    idle_line();
    if (load) begin
      load_strobe <= 1'b1;
      wt(4);
      load_strobe <= 1'b0;
      wt(8);
    end
  endtask
endmodule

// ==== verif/latch_loader_tb_top.sv ====
// Self-checking bench for the serial latch loader
`include "latch_loader_params.svh"

module latch_loader_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==================================================
  // Signals
  logic        aclk, aresetn, chip_enable, irq, serial_clk, serial_data, load_strobe;
  logic        reference_clock_in, rf_scaled_in, lock_detect_in, pump_drive_in;
  logic        mux_monitor_out, charge_pump_out, charge_pump_oe, powered_up;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0]  mon_tab [6] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h0};
  int          fails, n_checks;

  // 40 MHz clock
  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  latch_loader dut (
    .aclk, .aresetn, .serial_clk, .serial_data, .load_strobe, .chip_enable,
    .reference_clock_in, .rf_scaled_in, .lock_detect_in, .pump_drive_in,
    .mux_monitor_out, .charge_pump_out, .charge_pump_oe, .powered_up,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq
  );
  serial_host host (.aclk, .serial_clk, .serial_data, .load_strobe);

  // ==================================================
  // Helpers
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Control word: monitor source, power-down, pump off
  function automatic latch_loader_pkg::word_t ctl(input logic [2:0] m, input logic pd,
                                                  input logic off);
    return {3'h0, pd, 10'h000, off, 1'h0, m, 5'h00};
  endfunction

  // Bus write; bready up from the start until the response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic ah, wh, bh;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid & s_axi_bready;
      rr = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) s_axi_bready <= 1'b0;
    end while (!bh && n < 50);
    // One idle edge before the next request
    @(posedge aclk);
    if (!bh) begin
      fails++;
      final_report();
    end
  endtask

  // Bus read; rready up from the start until the data
  task automatic axi_rd(input logic [7:0] a);
    int   n;
    logic ah, rh;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid & s_axi_rready;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) s_axi_rready <= 1'b0;
    end while (!rh && n < 50);
    // One idle edge before the next request
    @(posedge aclk);
    if (!rh) begin
      fails++;
      final_report();
    end
  endtask

  // Read and compare data and response
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    axi_rd(a);
    chk(rd, e);
    chk(32'(rr), 32'(re));
  endtask

  // ==================================================
  // Main sequence
  initial begin
    aresetn = 1'b0;
    {chip_enable, reference_clock_in, rf_scaled_in, lock_detect_in, pump_drive_in} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Latches and shift register clear, bad addresses refused
    for (int a = 8; a <= 24; a += 4) begin
      rd_chk(8'(a), 32'h0000_0000, `RESP_OKAY);
    end
    rd_chk(8'h20, 32'h0000_0000, `RESP_SLVERR);
    rd_chk(8'h02, 32'h0000_0000, `RESP_SLVERR);
    axi_wr(`OFF_R_LATCH, 32'hffff_ffff);
    chk(32'(rr), 32'(`RESP_OKAY));
    rd_chk(`OFF_R_LATCH, 32'h0000_0000, `RESP_OKAY);
    axi_wr(8'h20, 32'h0000_0000);
    chk(32'(rr), 32'(`RESP_SLVERR));
    axi_wr(`OFF_MASK, 32'h0000_001f);
    chk(32'(rr), 32'(`RESP_OKAY));
    rd_chk(`OFF_MASK, 32'h0000_001f, `RESP_OKAY);
    // Lane 0 strobe off: mask keeps its value
    s_axi_wstrb <= 4'he;
    axi_wr(`OFF_MASK, 32'h0000_0000);
    s_axi_wstrb <= 4'hf;
    rd_chk(`OFF_MASK, 32'h0000_001f, `RESP_OKAY);
    chip_enable <= 1'b1;
    // Power-up order R, control, N; test latch left alone
    host.send_word(24'h12_3455, 1'b1);
    rd_chk(`OFF_R_LATCH, 32'h0012_3455, `RESP_OKAY);
    host.send_word(ctl(3'h1, 1'b0, 1'b0), 1'b1);
    rd_chk(`OFF_CTRL_LATCH, 32'(ctl(3'h1, 1'b0, 1'b0)), `RESP_OKAY);
    host.send_word(24'hab_cd0e, 1'b1);
    rd_chk(`OFF_N_LATCH, 32'h00ab_cd0e, `RESP_OKAY);
    rd_chk(`OFF_STATUS, 32'h0000_0017, `RESP_OKAY);
    chk(32'(irq), 32'h0000_0001);
    axi_wr(`OFF_STATUS, 32'h0000_001f);
    host.wt(3);
    chk(32'(irq), 32'h0000_0000);
    rd_chk(`OFF_STATUS, 32'h0000_0000, `RESP_OKAY);
    // Extra bits ahead of a word drop out; no strobe, no load
    host.send_byte(8'ha5);
    host.send_word(24'h5a_0f31, 1'b0);
    rd_chk(`OFF_SHIFT, 32'h005a_0f31, `RESP_OKAY);
    rd_chk(`OFF_R_LATCH, 32'h0012_3455, `RESP_OKAY);
    host.send_word(24'h5a_0f31, 1'b1);
    rd_chk(`OFF_R_LATCH, 32'h005a_0f31, `RESP_OKAY);
    // Power and pump states
    rd_chk(`OFF_STATE, 32'h0000_0007, `RESP_OKAY);
    host.send_word(ctl(3'h1, 1'b0, 1'b1), 1'b1);
    rd_chk(`OFF_STATE, 32'h0000_0003, `RESP_OKAY);
    host.send_word(ctl(3'h1, 1'b1, 1'b0), 1'b1);
    rd_chk(`OFF_STATE, 32'h0000_0002, `RESP_OKAY);
    host.send_word(ctl(3'h1, 1'b0, 1'b0), 1'b1);
    chip_enable <= 1'b0;
    host.wt(8);
    rd_chk(`OFF_STATE, 32'h0000_0000, `RESP_OKAY);
    chk(32'(charge_pump_oe), 32'h0000_0000);
    chip_enable <= 1'b1;
    host.wt(8);
    rd_chk(`OFF_STATE, 32'h0000_0007, `RESP_OKAY);
    // Every monitor source, the chosen one opposite to the rest
    foreach (mon_tab[k]) begin
      host.send_word(ctl(mon_tab[k], 1'b0, 1'b0), 1'b1);
      for (int v = 0; v < 2; v++) begin
        lock_detect_in <= v[0] ^ (mon_tab[k] != 3'h1);
        rf_scaled_in <= v[0] ^ (mon_tab[k] != 3'h2);
        reference_clock_in <= v[0] ^ (mon_tab[k] != 3'h3);
        pump_drive_in <= v[0];
        host.wt(8);
        chk(32'(mux_monitor_out),
            32'(mon_tab[k] == 3'h7 || (mon_tab[k] inside {[3'h1:3'h3]} && v[0])));
        chk(32'(charge_pump_out), 32'(v[0]));
      end
    end
    final_report();
  end
endmodule
